// file: sim/sib_checker.sv
`timescale 1ns/1ps
`include "sib_defines.vh"
// port watcher; mirrors software writes of enables, mask and port bits
module sib_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        txd_out,
  input wire        txd_oe,
  input wire        rx_full_irq,
  input wire        tx_empty_irq,
  input wire        tx_done_irq,
  input wire        rx_error_irq,
  input wire        irq
);
  logic [11:0] sh_q, sh_p, sh_d;
  wire         wr  = psel && penable && pready && pwrite;
  wire         map = paddr <= `SIB_A_PORT && paddr[1:0] == 2'h0;
  // next mirror value: enables, mask, port
  always @* begin
    sh_d = sh_q;
    if (wr && paddr == `SIB_A_CTRL) sh_d[11:9] = pwdata[8:6];
    if (wr && paddr == `SIB_A_MASK) sh_d[8:3] = pwdata[5:0];
    if (wr && paddr == `SIB_A_PORT) sh_d[2:0] = pwdata[2:0];
  end
  // one cycle of history, since outputs lag the register by a cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 12'h000;
      sh_p <= 12'h000;
    end else begin
      sh_q <= sh_d;
      sh_p <= sh_q;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  a_zero_wait: assert property (s_setup |=> s_access) else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held");
  a_slverr_map: assert property (pready |-> pslverr == !map) else $error("bad slave error");
  a_unmapped_read: assert property (pready && !map && !pwrite |-> prdata == 32'h0) else $error("bad read");
  a_txe_gate: assert property (!sh_q[10] && !sh_p[10] |-> !tx_empty_irq) else $error("empty irq");
  a_done_gate: assert property (!sh_q[11] && !sh_p[11] |-> !tx_done_irq) else $error("done irq");
  a_rx_gate: assert property (!sh_q[9] && !sh_p[9] |-> !rx_full_irq && !rx_error_irq)
    else $error("rx irq");
  a_mask_gate: assert property (sh_q[8:3] == 0 && sh_p[8:3] == 0 |-> !irq) else $error("masked irq");
  a_port_pin: assert property (sh_q[0] && sh_q[2:0] == sh_p[2:0] |-> txd_oe == sh_q[1] &&
    (!sh_q[1] || txd_out == sh_q[2])) else $error("port pin");
endmodule
bind sib_top sib_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd_out(txd_out), .txd_oe(txd_oe), .rx_full_irq(rx_full_irq),
  .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq), .rx_error_irq(rx_error_irq), .irq(irq));

// file: sim/sib_remote.sv
`timescale 1ns/1ps
// remote station: drives the rx line, decodes the tx line
module sib_remote #(
  parameter int BP = 32
) (
  input  wire  pclk,
  output logic rxd,
  input  wire  txd
);
  logic [7:0] got;
  initial rxd = 1'b1;
  // start, 8 bits lsb first, parity slot, stop; a one in the slot acts as a second stop
  task automatic send(input logic [7:0] b, input logic p);
    logic [10:0] f;
    f = {1'b1, p, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BP) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (BP) @(posedge pclk);
  endtask
  // holds the line at one level, so a break can last several frames
  task automatic level(input logic v);
    rxd <= v;
  endtask
  // mid-bit sampling after the start edge
  always @(negedge txd) begin
    repeat (BP + BP / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      got[i] = txd;
      repeat (BP) @(posedge pclk);
    end
  end
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps
`include "sib_defines.vh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire  [3:0]  iv;
  wire         pready, pslverr, rxd, txd, oe, irq;
  int          n_errors, check_count;
  sib_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_in(rxd), .txd_out(txd), .txd_oe(oe), .rx_full_irq(iv[0]), .tx_empty_irq(iv[1]),
    .tx_done_irq(iv[2]), .rx_error_irq(iv[3]), .irq(irq));
  sib_remote rem (.pclk(pclk), .rxd(rxd), .txd(txd));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one apb transfer, then two idle edges so registered outputs settle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic wait_irq(input int b);
    int k;
    for (k = 0; k < 5000 && iv[b] !== 1'b1; k++) @(posedge pclk);
    if (k == 5000) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic t_reset;
    bus(0, `SIB_A_STAT, 0);
    chk("status", rd, 32'h6);
    bus(0, 8'h1C, 0);
    chk("unmapped error", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    bus(1, `SIB_A_CTRL, 32'h180);
    chk("early irqs", iv, 4'h6);
    bus(1, `SIB_A_MASK, 32'h6);
    chk("irq", irq, 1'b1);
    bus(1, `SIB_A_MASK, 0);
    bus(1, `SIB_A_CTRL, 0);
    chk("irqs off", {irq, iv}, 5'h0);
  endtask
  task automatic t_tx;
    bus(1, `SIB_A_TXD, 32'hA5);
    bus(0, `SIB_A_STAT, 0);
    chk("empty done clear", rd[2:1], 2'b00);
    bus(1, `SIB_A_CTRL, 32'h181);
    wait_irq(2);
    chk("tx byte", rem.got, 8'hA5);
  endtask
  task automatic t_rx;
    bus(1, `SIB_A_CTRL, 32'h42);
    rem.send(8'h3C, 1'b1);
    chk("full irq", iv[0], 1'b1);
    bus(0, `SIB_A_RXD, 0);
    chk("rx byte", rd, 32'h3C);
  endtask
  // same frame read with odd then even parity: right, then wrong
  task automatic t_parity;
    bus(1, `SIB_A_CTRL, 32'h5A);
    rem.send(8'h3C, 1'b1);
    bus(0, `SIB_A_RXD, 0);
    chk("odd byte", rd, 32'h3C);
    chk("odd no error", iv[3], 1'b0);
    bus(1, `SIB_A_CTRL, 32'h4A);
    rem.send(8'h3C, 1'b1);
    chk("parity irq", iv[3], 1'b1);
    bus(0, `SIB_A_STAT, 0);
    chk("parity flag", rd[5:0], 6'h27);
    bus(1, `SIB_A_STAT, 32'h21);
    bus(1, `SIB_A_CTRL, 32'h42);
  endtask
  // break held over several frames: a cleared framing flag comes back
  task automatic t_break;
    rem.level(1'b0);
    repeat (12 * rem.BP) @(posedge pclk);
    chk("error irq", iv[3], 1'b1);
    bus(1, `SIB_A_STAT, 32'h10);
    repeat (12 * rem.BP) @(posedge pclk);
    bus(0, `SIB_A_STAT, 0);
    chk("framing again", rd[4], 1'b1);
    chk("overrun", rd[3], 1'b1);
    rem.level(1'b1);
    repeat (12 * rem.BP) @(posedge pclk);
    bus(1, `SIB_A_CTRL, 0);
    bus(0, `SIB_A_STAT, 0);
    chk("framing kept", rd[4], 1'b1);
  endtask
  // errors still pending block a clocked transmit until cleared
  task automatic t_sync_port;
    bus(1, `SIB_A_CTRL, 32'h5);
    bus(1, `SIB_A_TXD, 32'h11);
    repeat (400) @(posedge pclk);
    bus(0, `SIB_A_STAT, 0);
    chk("blocked", rd[2:1], 2'b00);
    bus(1, `SIB_A_STAT, 32'h3F);
    bus(1, `SIB_A_CTRL, 32'h85);
    wait_irq(1);
    bus(1, `SIB_A_PORT, 32'h6);
    bus(1, `SIB_A_PORT, 32'h7);
    chk("mark", {oe, txd}, 2'b11);
    bus(1, `SIB_A_PORT, 32'h3);
    chk("break out", {oe, txd}, 2'b10);
  endtask
  // free-running clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_parity();
    t_break();
    t_sync_port();
    end_of_test();
  end
endmodule

// file: src/sib_defines.vh
`ifndef SIB_DEFINES_VH
`define SIB_DEFINES_VH
`define SIB_A_CTRL    8'h00
`define SIB_A_STAT    8'h04
`define SIB_A_TXD     8'h08
`define SIB_A_RXD     8'h0C
`define SIB_A_MASK    8'h10
`define SIB_A_BAUD    8'h14
`define SIB_A_PORT    8'h18
// control bits
`define SIB_C_TE      0
`define SIB_C_RE      1
`define SIB_C_SYNC    2
`define SIB_C_PAR     3
`define SIB_C_ODD     4
`define SIB_C_STOP2   5
`define SIB_C_RIE     6
`define SIB_C_TIE     7
`define SIB_C_TX_DONE_IRQ_EN    8
// status bits, also mask and irq status layout
`define SIB_S_RXF     0
`define SIB_S_TXE     1
`define SIB_S_TXD     2
`define SIB_S_OVR     3
`define SIB_S_FER     4
`define SIB_S_PER     5
`define SIB_S_RST     6'h06
// port bits
`define SIB_P_SEL     0
`define SIB_P_DIR     1
`define SIB_P_LVL     2
`define SIB_OVS       4'hF
`define SIB_MID       4'h7
`define SIB_BAUD_RST  16'h0001
`endif

// file: src/sib_rx.v
`timescale 1ns/1ps
`include "sib_defines.vh"
// async receiver, 8 data bits, optional parity, one stop
module sib_rx (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       tick16,
  input  wire       en,
  input  wire       par_en,
  input  wire       par_odd,
  input  wire       rxd,
  output reg        done,
  output reg  [7:0] data,
  output reg        framing_error_flag,
  output reg        per
);
  localparam IDLE = 2'b00;
  localparam BITS = 2'b01;
  reg [1:0] st_q;
  reg [3:0] sub_q;
  reg [3:0] idx_q;
  reg [9:0] sh_q;
  reg       prev_q;
  wire [3:0] last = par_en ? 4'hA : 4'h9;
  // start edge found on 16x tick, then mid-bit sampling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= IDLE; sub_q <= 4'h0; idx_q <= 4'h0; sh_q <= 10'h000;
      prev_q <= 1'b1; done <= 1'b0; data <= 8'h00; framing_error_flag <= 1'b0; per <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick16) begin
        prev_q <= rxd;
        case (st_q)
          IDLE: begin
            // break keeps producing frames, so stays receiving
            // a line held low after a framing error starts the next frame at once
            if (en && !rxd && (prev_q || framing_error_flag)) begin
              st_q <= BITS; sub_q <= 4'h0; idx_q <= 4'h0;
            end
          end
          BITS: begin
            sub_q <= sub_q + 4'h1;
            if (sub_q == `SIB_MID) begin
              sh_q <= {rxd, sh_q[9:1]};
              if (idx_q == last) begin
                st_q  <= IDLE;
                done  <= 1'b1;
                data  <= par_en ? sh_q[8:1] : sh_q[9:2];
                framing_error_flag   <= !rxd;
                per   <= par_en && ((^sh_q[9:1]) ^ par_odd);
              end
              idx_q <= idx_q + 4'h1;
            end
          end
          default: st_q <= IDLE;
        endcase
      end
    end
  end
endmodule

// file: src/sib_top.v
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "sib_defines.vh"
// serial block top: apb registers, flags, irqs, pin override
module sib_top #(
  parameter BAUD_W = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rxd_in,
  output reg         txd_out,
  output reg         txd_oe,
  output reg         rx_full_irq,
  output reg         tx_empty_irq,
  output reg         tx_done_irq,
  output reg         rx_error_irq,
  output reg         irq
);
  reg [8:0]        serial_control_reg_q;
  reg [5:0]        serial_status_reg_q;
  reg [5:0]        mask_q;
  reg [7:0]        tx_holding_reg_q;
  reg [7:0]        rx_data_q;
  reg [BAUD_W-1:0] baud_q;
  reg [2:0]        port_mode_reg_q;
  reg [BAUD_W-1:0] div_q;
  reg [3:0]        ovs_q;
  reg              tick16_q;
  reg              tick_q;
  wire rx_done;
  wire [7:0] rx_byte;
  wire rx_fer;
  wire rx_per;
  wire tx_busy;
  wire tx_last;
  wire tx_pin;
  wire [8:0] ctl = serial_control_reg_q;
  wire [5:0] st = serial_status_reg_q;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd_rx = acc && !pwrite && paddr == `SIB_A_RXD;
  wire wr_tdr = wr && paddr == `SIB_A_TXD;
  wire wr_stat = wr && paddr == `SIB_A_STAT;
  wire errs = st[`SIB_S_OVR] | st[`SIB_S_FER] | st[`SIB_S_PER];

  function mapped;
    input [7:0] a;
    begin
      mapped = a == `SIB_A_CTRL || a == `SIB_A_STAT || a == `SIB_A_TXD || a == `SIB_A_RXD ||
               a == `SIB_A_MASK || a == `SIB_A_BAUD || a == `SIB_A_PORT;
    end
  endfunction

  // basic clock at sixteen times bit rate, bit tick every 16th
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= {BAUD_W{1'b0}}; ovs_q <= 4'h0; tick16_q <= 1'b0; tick_q <= 1'b0;
    end else begin
      tick16_q <= 1'b0;
      tick_q <= 1'b0;
      if (div_q >= baud_q) begin
        div_q <= {BAUD_W{1'b0}};
        tick16_q <= 1'b1;
        ovs_q <= ovs_q + 4'h1;
        if (ovs_q == `SIB_OVS)
          tick_q <= 1'b1;
      end else begin
        div_q <= div_q + {{(BAUD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  sib_rx u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .tick16  (tick16_q),
    .en      (ctl[`SIB_C_RE]),
    .par_en  (ctl[`SIB_C_PAR]),
    .par_odd (ctl[`SIB_C_ODD]),
    .rxd     (rxd_in),
    .done    (rx_done),
    .data    (rx_byte),
    .framing_error_flag     (rx_fer),
    .per     (rx_per)
  );

  // sync mode refuses to start while any receive error stands
  wire tx_go = ctl[`SIB_C_TE] && !st[`SIB_S_TXE] && !tx_busy &&
               !(ctl[`SIB_C_SYNC] && errs);

  sib_tx u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_q),
    .start   (tx_go),
    .din     (tx_holding_reg_q),
    .par_en  (ctl[`SIB_C_PAR]),
    .par_odd (ctl[`SIB_C_ODD]),
    .stop2   (ctl[`SIB_C_STOP2]),
    .busy    (tx_busy),
    .last    (tx_last),
    .txd     (tx_pin)
  );

  // status flags: hardware set wins over write-one clear
  reg [5:0] st_d;
  always @* begin
    st_d = st;
    if (wr_stat)
      st_d = st & ~pwdata[5:0];
    if (rd_rx)
      st_d[`SIB_S_RXF] = 1'b0;
    if (wr_tdr) begin
      st_d[`SIB_S_TXE] = 1'b0;
      st_d[`SIB_S_TXD] = 1'b0;
    end
    if (tx_go)
      st_d[`SIB_S_TXE] = 1'b1;
    if (tx_last && st[`SIB_S_TXE] && !tx_go)
      st_d[`SIB_S_TXD] = 1'b1;
    if (rx_done) begin
      if (st[`SIB_S_RXF] && !rd_rx)
        st_d[`SIB_S_OVR] = 1'b1;
      else
        st_d[`SIB_S_RXF] = 1'b1;
      if (rx_fer)
        st_d[`SIB_S_FER] = 1'b1;
      if (rx_per)
        st_d[`SIB_S_PER] = 1'b1;
    end
  end

  // register file and flag storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_reg_q <= 9'h000;
      serial_status_reg_q  <= `SIB_S_RST;
      mask_q <= 6'h00; tx_holding_reg_q <= 8'h00; rx_data_q <= 8'h00;
      baud_q <= `SIB_BAUD_RST; port_mode_reg_q <= 3'h0;
    end else begin
      serial_status_reg_q <= st_d;
      if (rx_done && !(st[`SIB_S_RXF] && !rd_rx))
        rx_data_q <= rx_byte;
      if (wr && paddr == `SIB_A_CTRL)
        serial_control_reg_q <= pwdata[8:0];
      if (wr && paddr == `SIB_A_MASK)
        mask_q <= pwdata[5:0];
      if (wr_tdr)
        tx_holding_reg_q <= pwdata[7:0];
      if (wr && paddr == `SIB_A_BAUD)
        baud_q <= pwdata[BAUD_W-1:0];
      if (wr && paddr == `SIB_A_PORT)
        port_mode_reg_q <= pwdata[2:0];
    end
  end

  // apb answer: zero wait, registered read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000; pready <= 1'b0; pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SIB_A_CTRL: prdata <= {23'h000000, serial_control_reg_q};
          `SIB_A_STAT: prdata <= {26'h0000000, serial_status_reg_q};
          `SIB_A_TXD:  prdata <= {24'h000000, tx_holding_reg_q};
          `SIB_A_RXD:  prdata <= {24'h000000, rx_data_q};
          `SIB_A_MASK: prdata <= {26'h0000000, mask_q};
          `SIB_A_BAUD: prdata <= {{(32-BAUD_W){1'b0}}, baud_q};
          `SIB_A_PORT: prdata <= {29'h00000000, port_mode_reg_q};
          default:     prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // pin override and irqs, all registered; each irq line = flag and enable, irq = any flag and mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out <= 1'b1; txd_oe <= 1'b0;
      rx_full_irq <= 1'b0; tx_empty_irq <= 1'b0; tx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0; irq <= 1'b0;
    end else begin
      if (port_mode_reg_q[`SIB_P_SEL]) begin
        txd_out <= port_mode_reg_q[`SIB_P_LVL];
        txd_oe  <= port_mode_reg_q[`SIB_P_DIR];
      end else begin
        txd_out <= tx_pin;
        txd_oe  <= ctl[`SIB_C_TE];
      end
      rx_full_irq  <= st_d[`SIB_S_RXF] & ctl[`SIB_C_RIE];
      tx_empty_irq <= st_d[`SIB_S_TXE] & ctl[`SIB_C_TIE];
      tx_done_irq  <= st_d[`SIB_S_TXD] & ctl[`SIB_C_TX_DONE_IRQ_EN];
      rx_error_irq <= (st_d[`SIB_S_OVR] | st_d[`SIB_S_FER] | st_d[`SIB_S_PER]) & ctl[`SIB_C_RIE];
      irq <= |(st_d & mask_q);
    end
  end
endmodule

// file: src/sib_tx.v
`timescale 1ns/1ps
`include "sib_defines.vh"
// transmitter; one tick per bit, start, 8 data, parity, stops
module sib_tx (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       tick,
  input  wire       start,
  input  wire [7:0] din,
  input  wire       par_en,
  input  wire       par_odd,
  input  wire       stop2,
  output reg        busy,
  output reg        last,
  output reg        txd
);
  reg [10:0] sh_q;
  reg [3:0]  cnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0; last <= 1'b0; txd <= 1'b1; sh_q <= 11'h7FF; cnt_q <= 4'h0;
    end else begin
      last <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        sh_q  <= par_en ? {1'b1, (^din) ^ par_odd, din, 1'b0} : {2'b11, din, 1'b0};
        cnt_q <= 4'h9 + {3'b000, par_en} + {3'b000, stop2};
      end else if (busy && tick) begin
        txd   <= sh_q[0];
        sh_q  <= {1'b1, sh_q[10:1]};
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h0) begin
          busy <= 1'b0;
          last <= 1'b1;
        end
      end
    end
  end
endmodule
